/* File: design/slfr_defs.svh */
// Offsets, field positions, reset values of the level and
// frequency register group.
// Assumes byte addressing on a 12-bit register port.
`ifndef SLFR_DEFS_SVH
`define SLFR_DEFS_SVH

// ****************************************************
// Register offsets
// ****************************************************
`define SLFR_OFS_FI 12'h034
`define SLFR_OFS_STAT 12'h420
`define SLFR_OFS_OVR 12'h424

// ****************************************************
// Field positions
// ****************************************************
`define SLFR_FI_OFS_MSB 13
`define SLFR_FI_OFS_LSB 1
`define SLFR_FI_SUB_BIT 0
`define SLFR_FI_RSV_LSB 14
`define SLFR_TX_MSB 30
`define SLFR_TX_LSB 26
`define SLFR_LOS_MSB 25
`define SLFR_LOS_LSB 21
`define SLFR_AC_MSB 20
`define SLFR_AC_LSB 16
`define SLFR_OVR_EN_BIT 31

// ****************************************************
// Reset and nominal values
// ****************************************************
`define SLFR_FI_RST 32'h0000_0000
`define SLFR_TX_NOM 5'h10
`define SLFR_LOS_NOM 5'h12
`define SLFR_AC_NOM 5'h00
`define SLFR_OVR_LVL_RST 5'h10
`define SLFR_OVR_LOW_RST 16'h0000
`define SLFR_STAT_HI 1'h1
`define SLFR_STAT_LO 16'hFFFF
`define SLFR_RD_IDLE 32'h0000_0000

// One offset step in ppm of the reference
`define SLFR_FREQ_PPM_PER_LSB 1.526

`endif

/* File: design/slfr_pkg.sv */
// Types of the level and frequency register group.
// Assumes nothing beyond the defs header.
package slfr_pkg;

  typedef logic [11:0] slfr_addr_type;
  typedef logic [31:0] slfr_word_type;
  typedef logic [4:0] slfr_lvl_type;
  typedef logic [12:0] slfr_fofs_type;

  // One-hot register select
  typedef enum logic [3:0] {
    SLFR_SEL_NONE = 4'b0001,
    SLFR_SEL_FI = 4'b0010,
    SLFR_SEL_STAT = 4'b0100,
    SLFR_SEL_OVR = 4'b1000
  } slfr_sel_type;

endpackage : slfr_pkg

/* File: design/slfr_regs.sv */
// Debug and trim registers of a serial link transceiver:
// frequency readout, level status and level override.
// Assumes a single-cycle register port on MCLK_I; level
// and frequency inputs come from another domain.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`include "slfr_defs.svh"

module slfr_regs (
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  // Register port
  input wire slfr_pkg::slfr_addr_type ADDR_I,
  input wire slfr_pkg::slfr_word_type WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output slfr_pkg::slfr_word_type RDATA_O,
  // Frequency integrator
  input wire slfr_pkg::slfr_fofs_type FREQ_OFFSET_VALUE_I,
  input wire logic FREQ_SUBRESOLUTION_BIT_I,
  // Level control inputs
  input wire slfr_pkg::slfr_lvl_type TX_LEVEL_I,
  input wire slfr_pkg::slfr_lvl_type SIGNAL_LOSS_THRESHOLD_I,
  input wire slfr_pkg::slfr_lvl_type AC_SCAN_COMPARATOR_LEVEL_I,
  // Levels in effect
  output slfr_pkg::slfr_lvl_type TX_LEVEL_O,
  output slfr_pkg::slfr_lvl_type SIGNAL_LOSS_THRESHOLD_O,
  output slfr_pkg::slfr_lvl_type AC_SCAN_COMPARATOR_LEVEL_O,
  output logic LEVEL_OVERRIDE_ENABLE_O
);
  import slfr_pkg::*;

  // ****************************************************
  // Address decode
  // ****************************************************
  function automatic slfr_sel_type sel_f(
    input slfr_addr_type a
  );
    case (a)
      `SLFR_OFS_FI: sel_f = SLFR_SEL_FI;
      `SLFR_OFS_STAT: sel_f = SLFR_SEL_STAT;
      `SLFR_OFS_OVR: sel_f = SLFR_SEL_OVR;
      default: sel_f = SLFR_SEL_NONE;
    endcase
  endfunction : sel_f

  slfr_sel_type acc_sel;
  logic wr_fi;
  logic wr_ovr;
  logic rd_fi;
  logic rd_stat;
  logic rd_ovr;

  assign acc_sel = sel_f(ADDR_I);
  assign wr_fi = WR_I && (acc_sel == SLFR_SEL_FI);
  assign wr_ovr = WR_I && (acc_sel == SLFR_SEL_OVR);
  assign rd_fi = RD_I && (acc_sel == SLFR_SEL_FI);
  assign rd_stat = RD_I && (acc_sel == SLFR_SEL_STAT);
  assign rd_ovr = RD_I && (acc_sel == SLFR_SEL_OVR);

  // ****************************************************
  // Input synchronisers
  // ****************************************************
  // All foreign inputs in one bundle; bits may land one
  // cycle apart, which software tolerates by reading twice
  localparam int SW = 29;
  localparam logic [SW-1:0] SYNC_RST = {
    13'h0000, 1'h0,
    `SLFR_TX_NOM, `SLFR_LOS_NOM, `SLFR_AC_NOM};

  logic [SW-1:0] sync1_ff;
  logic [SW-1:0] sync2_ff;
  logic [SW-1:0] async_in;

  assign async_in = {FREQ_OFFSET_VALUE_I,
    FREQ_SUBRESOLUTION_BIT_I, TX_LEVEL_I,
    SIGNAL_LOSS_THRESHOLD_I, AC_SCAN_COMPARATOR_LEVEL_I};

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sync1_ff <= SYNC_RST;
      sync2_ff <= SYNC_RST;
    end else begin
      sync1_ff <= async_in;
      sync2_ff <= sync1_ff;
    end
  end

  slfr_fofs_type s_fofs;
  logic s_fsub;
  slfr_lvl_type s_tx;
  slfr_lvl_type s_los;
  slfr_lvl_type s_ac;

  assign s_fofs = sync2_ff[28:16];
  assign s_fsub = sync2_ff[15];
  assign s_tx = sync2_ff[14:10];
  assign s_los = sync2_ff[9:5];
  assign s_ac = sync2_ff[4:0];

  // ****************************************************
  // Frequency integrator readout
  // ****************************************************
  // Read returns the old snapshot and takes a fresh one
  slfr_word_type fi_ff;
  slfr_word_type nxt_fi;

  always_comb begin
    nxt_fi = fi_ff;
    if (wr_fi) begin
      nxt_fi = WDATA_I;
    end else if (rd_fi) begin
      nxt_fi[`SLFR_FI_OFS_MSB:`SLFR_FI_OFS_LSB] = s_fofs;
      nxt_fi[`SLFR_FI_SUB_BIT] = s_fsub;
    end
  end

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      fi_ff <= `SLFR_FI_RST;
    end else begin
      fi_ff <= nxt_fi;
    end
  end

  // ****************************************************
  // Level override register
  // ****************************************************
  slfr_word_type ovr_ff;
  slfr_word_type nxt_ovr;

  always_comb begin
    nxt_ovr = ovr_ff;
    if (wr_ovr) begin
      nxt_ovr = WDATA_I;
    end
  end

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ovr_ff <= {1'h0, `SLFR_OVR_LVL_RST,
        `SLFR_OVR_LVL_RST, `SLFR_OVR_LVL_RST,
        `SLFR_OVR_LOW_RST};
    end else begin
      ovr_ff <= nxt_ovr;
    end
  end

  logic ovr_en;
  slfr_lvl_type o_tx;
  slfr_lvl_type o_los;
  slfr_lvl_type o_ac;

  assign ovr_en = ovr_ff[`SLFR_OVR_EN_BIT];
  assign o_tx = ovr_ff[`SLFR_TX_MSB:`SLFR_TX_LSB];
  assign o_los = ovr_ff[`SLFR_LOS_MSB:`SLFR_LOS_LSB];
  assign o_ac = ovr_ff[`SLFR_AC_MSB:`SLFR_AC_LSB];

  // ****************************************************
  // Levels in effect
  // ****************************************************
  // All three switch together, never one alone
  slfr_lvl_type tx_ff;
  slfr_lvl_type los_ff;
  slfr_lvl_type ac_ff;
  logic en_ff;
  slfr_lvl_type nxt_tx;
  slfr_lvl_type nxt_los;
  slfr_lvl_type nxt_ac;

  always_comb begin
    if (ovr_en) begin
      nxt_tx = o_tx;
      nxt_los = o_los;
      nxt_ac = o_ac;
    end else begin
      nxt_tx = s_tx;
      nxt_los = s_los;
      nxt_ac = s_ac;
    end
  end

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      tx_ff <= `SLFR_TX_NOM;
      los_ff <= `SLFR_LOS_NOM;
      ac_ff <= `SLFR_AC_NOM;
      en_ff <= 1'h0;
    end else begin
      tx_ff <= nxt_tx;
      los_ff <= nxt_los;
      ac_ff <= nxt_ac;
      en_ff <= ovr_en;
    end
  end

  assign TX_LEVEL_O = tx_ff;
  assign SIGNAL_LOSS_THRESHOLD_O = los_ff;
  assign AC_SCAN_COMPARATOR_LEVEL_O = ac_ff;
  assign LEVEL_OVERRIDE_ENABLE_O = en_ff;

  // ****************************************************
  // Read data
  // ****************************************************
  // Status shows the inputs even under override, so it
  // then differs from the levels in effect
  slfr_word_type stat_w;
  slfr_word_type rdata_ff;
  slfr_word_type nxt_rdata;

  assign stat_w = {`SLFR_STAT_HI, s_tx, s_los, s_ac,
    `SLFR_STAT_LO};

  always_comb begin
    nxt_rdata = `SLFR_RD_IDLE;
    if (rd_fi) begin
      nxt_rdata = fi_ff;
    end else if (rd_stat) begin
      nxt_rdata = stat_w;
    end else if (rd_ovr) begin
      nxt_rdata = ovr_ff;
    end
  end

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rdata_ff <= `SLFR_RD_IDLE;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign RDATA_O = rdata_ff;

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RSTN_I);

  AST_FI_RESET:
    assert property ($rose(RSTN_I) |-> fi_ff == 32'h0)
    else $error("readout not clear after reset");

  AST_FI_CAPTURE:
    assert property (rd_fi && !WR_I |=>
      fi_ff[13:1] == $past(s_fofs) &&
      fi_ff[31:14] == $past(fi_ff[31:14]))
    else $error("offset not captured on read");

  AST_FI_SUB:
    assert property (rd_fi |=> fi_ff[0] == $past(s_fsub))
    else $error("sub-resolution bit not captured");

  AST_FI_STALE:
    assert property (rd_fi ##1 RD_I && rd_fi |=>
      RDATA_O == $past(fi_ff))
    else $error("second read not from snapshot");

  AST_STAT_READ:
    assert property (rd_stat |=>
      RDATA_O == {1'h1, $past(s_tx), $past(s_los),
      $past(s_ac), 16'hFFFF})
    else $error("status read data wrong");

  AST_STAT_IGNORES_OVR:
    assert property (rd_stat && ovr_en |=>
      RDATA_O[30:26] == $past(s_tx))
    else $error("status shows override level");

  AST_STAT_FOLLOWS:
    assert property (s_tx != $past(s_tx) ##0 rd_stat |=>
      RDATA_O[30:26] == $past(s_tx))
    else $error("status misses input change");

  AST_OVR_RESET:
    assert property ($rose(RSTN_I) |->
      ovr_ff[31:16] == 16'h4210)
    else $error("override reset value wrong");

  AST_OVR_WRITE:
    assert property (wr_ovr |=> ovr_ff == $past(WDATA_I))
    else $error("override write not stored");

  AST_OVR_APPLY:
    assert property (ovr_en |=> TX_LEVEL_O == $past(o_tx) &&
      SIGNAL_LOSS_THRESHOLD_O == $past(o_los))
    else $error("override write not applied");

  AST_OVR_ALL:
    assert property (ovr_en ##1 ovr_en && $stable(ovr_ff)
      |-> AC_SCAN_COMPARATOR_LEVEL_O == o_ac &&
      LEVEL_OVERRIDE_ENABLE_O)
    else $error("comparator level not overridden");

  AST_NO_OVR:
    assert property (!ovr_en |=>
      TX_LEVEL_O == $past(s_tx) &&
      SIGNAL_LOSS_THRESHOLD_O == $past(s_los) &&
      AC_SCAN_COMPARATOR_LEVEL_O == $past(s_ac))
    else $error("input levels not passed through");

  AST_UNMAPPED:
    assert property (RD_I && acc_sel == SLFR_SEL_NONE |=>
      RDATA_O == 32'h0)
    else $error("unmapped read not zero");

  AST_RD_ONE_CYCLE:
    assert property (!RD_I |=> RDATA_O == 32'h0)
    else $error("read data held too long");

  COV_DOUBLE_READ:
    cover property (rd_fi ##1 rd_fi);

  COV_OVR_ON:
    cover property (wr_ovr && WDATA_I[31] ##2 ovr_en);

  COV_STAT_UNDER_OVR:
    cover property (ovr_en && rd_stat);

  COV_OVR_OFF:
    cover property ($fell(ovr_en) ##1 !ovr_en);

endmodule : slfr_regs

/* File: dv/slfr_regs_bench.sv */
// Self-checking bench for the level and frequency registers.
// Assumes the design files are compiled first; bench drives all ports.
`timescale 1ns/1ps
`include "slfr_defs.svh"

module slfr_regs_bench;
  import slfr_pkg::*;

  logic mclk;
  logic rst_n;
  slfr_addr_type addr;
  slfr_word_type wdata;
  slfr_word_type rdata;
  logic wr;
  logic rd;
  logic rd_d;
  slfr_fofs_type fofs;
  logic fsub;
  slfr_lvl_type tx_in, los_in, ac_in, tx_out, los_out, ac_out, t;
  logic ovr_en;
  slfr_word_type exp_q[$];
  slfr_word_type snap;
  slfr_word_type w;
  logic [15:0] seed;
  int err_count;
  int checks_done;

  slfr_regs DUT (
    .MCLK_I(mclk), .RSTN_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .FREQ_OFFSET_VALUE_I(fofs), .FREQ_SUBRESOLUTION_BIT_I(fsub),
    .TX_LEVEL_I(tx_in), .SIGNAL_LOSS_THRESHOLD_I(los_in),
    .AC_SCAN_COMPARATOR_LEVEL_I(ac_in), .TX_LEVEL_O(tx_out),
    .SIGNAL_LOSS_THRESHOLD_O(los_out), .AC_SCAN_COMPARATOR_LEVEL_O(ac_out),
    .LEVEL_OVERRIDE_ENABLE_O(ovr_en)
  );

  // ****************************************************
  // Helpers
  // ****************************************************
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic slfr_word_type stat();
    return {`SLFR_STAT_HI, tx_in, los_in, ac_in, `SLFR_STAT_LO};
  endfunction : stat

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("Checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  // Strobe stays up until idle, so accesses may run back to back
  task automatic acc(input logic wen, input slfr_addr_type a,
                     input slfr_word_type d);
    @(posedge mclk);
    wr <= wen;
    rd <= !wen;
    addr <= a;
    wdata <= d;
    if (!wen) exp_q.push_back(d);
  endtask : acc

  task automatic idle(input int n);
    repeat (n) begin
      @(posedge mclk);
      wr <= 1'b0;
      rd <= 1'b0;
    end
  endtask : idle

  // Read returns the old snapshot, then captures the inputs
  task automatic rd_fi();
    acc(1'b0, `SLFR_OFS_FI, snap);
    snap = {snap[31:14], fofs, fsub};
  endtask : rd_fi

  task automatic lv(input slfr_lvl_type et, el, ea, input logic ee);
    check("tx_level", tx_out, et);
    check("loss_level", los_out, el);
    check("comparator_level", ac_out, ea);
    check("override_enable", ovr_en, ee);
  endtask : lv

  // ****************************************************
  // Read data monitor
  // ****************************************************
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_d <= 1'b0;
    end else begin
      if (rd_d && exp_q.size() == 0)
        check("read_queue", 32'h1, 32'h0);
      else if (rd_d)
        check("read_data", rdata, exp_q.pop_front());
      else if (rdata !== `SLFR_RD_IDLE)
        check("read_idle", rdata, `SLFR_RD_IDLE);
      rd_d <= rd;
    end
  end

  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    conclude();
  end

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    rst_n = 1'b0;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    fofs = 13'h0000;
    fsub = 1'b0;
    tx_in = 5'h1F;
    los_in = 5'h03;
    ac_in = 5'h0A;
    seed = 16'h001A;
    err_count = 0;
    checks_done = 0;
    snap = `SLFR_FI_RST;
    repeat (7) @(posedge mclk);
    #1 lv(5'h10, 5'h12, 5'h00, 1'b0);
    @(posedge mclk);
    rst_n <= 1'b1;
    rd_fi();
    acc(1'b0, `SLFR_OFS_OVR, 32'h4210_0000);
    acc(1'b0, `SLFR_OFS_STAT, stat());
    idle(1);
    #1 lv(tx_in, los_in, ac_in, 1'b0);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      @(posedge mclk);
      fofs <= (i == 0) ? 13'h1000 : (i == 1) ? 13'h1FFF : seed[12:0];
      fsub <= seed[15];
      idle(3);
      rd_fi();
      rd_fi();
      idle(1);
    end
    acc(1'b1, `SLFR_OFS_FI, 32'hA5A5_5A5A);
    snap = 32'hA5A5_5A5A;
    rd_fi();
    rd_fi();
    idle(1);
    $display("test readout done");
    acc(1'b1, `SLFR_OFS_STAT, 32'h0000_0000);
    acc(1'b1, 12'h038, 32'hFFFF_FFFF);
    acc(1'b0, 12'h038, 32'h0000_0000);
    acc(1'b0, 12'hC34, 32'h0000_0000);
    acc(1'b0, `SLFR_OFS_STAT, stat());
    idle(1);
    $display("test refusals done");
    for (int i = 0; i < 2; i++) begin
      // Transmit code kept at or above the 1 V setting
      t = i ? 5'h1F : 5'h10;
      // Low half written back as it reads after reset
      w = {1'b1, t, 5'h15, 5'h07, 16'h0000};
      acc(1'b1, `SLFR_OFS_OVR, w);
      acc(1'b0, `SLFR_OFS_OVR, w);
      idle(3);
      #1 lv(t, 5'h15, 5'h07, 1'b1);
      acc(1'b0, `SLFR_OFS_STAT, stat());
      idle(1);
    end
    acc(1'b1, `SLFR_OFS_OVR, w & 32'h7FFF_FFFF);
    idle(3);
    #1 lv(tx_in, los_in, ac_in, 1'b0);
    $display("test override done");
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      @(posedge mclk);
      tx_in <= seed[4:0];
      los_in <= seed[9:5];
      ac_in <= seed[14:10];
      // Read lands on the edge at which the new levels arrive
      idle(1);
      acc(1'b0, `SLFR_OFS_STAT, stat());
      idle(2);
      #1 lv(tx_in, los_in, ac_in, 1'b0);
    end
    $display("test level inputs done");
    acc(1'b1, `SLFR_OFS_OVR, 32'hFFFF_0000);
    idle(3);
    @(posedge mclk);
    rst_n <= 1'b0;
    idle(2);
    #1 lv(5'h10, 5'h12, 5'h00, 1'b0);
    @(posedge mclk);
    rst_n <= 1'b1;
    snap = `SLFR_FI_RST;
    acc(1'b0, `SLFR_OFS_OVR, 32'h4210_0000);
    idle(3);
    rd_fi();
    idle(3);
    $display("test second reset done");
    conclude();
  end

endmodule : slfr_regs_bench
